//--- ossu_state_save_unit.sv
// optimized and compacted state save engine behind an axi4-lite register slave
`timescale 1ns/10ps

module ossu_state_save_unit
   import ossu_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   // axi4-lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read address
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   // axi4-lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // save completion
   output logic             save_done,
   output logic             save_fault
);

   // byte-lane merge, used by every writable word except the control word
   function automatic logic [31:0] merge_strb(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = new_word[8*b +: 8];
         end
      end
      return res;
   endfunction

   // bus handshake state
   logic                 aw_hold;
   logic                 w_hold;
   logic [7:0]           aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 next_aw_hold;
   logic                 next_w_hold;
   logic                 next_rvalid;
   logic                 wr_fire;
   logic                 ar_fire;
   logic                 wr_hit;
   logic [31:0]          rd_word;
   logic                 rd_hit;

   // software-loaded context
   logic [FLG_W-1:0]     cpu_flags;
   logic [31:0]          simd_csr;
   logic [63:0]          feat_mask;
   logic [63:0]          instr_mask;
   logic [63:0]          in_use;
   logic [63:0]          modified;
   logic [63:0]          save_addr;

   // save-area header image and results
   logic [63:0]          hdr_present;
   logic [63:0]          hdr_compact;
   logic [63:0]          store_mask;
   logic [63:0]          requested_component_mask;
   logic                 op_compact;
   ossu_fault_e          fault;
   logic                 mod_used;
   logic                 csr_stored;
   logic                 compact_layout;
   logic                 done_flag;
   ossu_state_e          state;

   // last-restore record
   logic                 lrr_valid;
   logic [1:0]           lrr_cpl;
   logic                 lrr_nonroot;
   logic [63:0]          lrr_addr;
   logic [63:0]          lrr_comp;

   // derived terms
   logic [1:0]           current_privilege_level;
   logic                 ctrl_wr;
   logic                 start_req;
   logic                 record_req;
   ossu_fault_e          next_fault;
   logic                 mod_eligible;
   logic                 csr_not_init;
   logic [63:0]          c_present;
   logic [63:0]          c_store;
   logic [63:0]          o_store;

   assign current_privilege_level = cpu_flags[FLG_CPL_LSB +: 2];

   // write channel: address and data are taken independently, in any order
   always_comb
   begin
      next_aw_hold = aw_hold;
      next_w_hold  = w_hold;
      if (awvalid && awready)
      begin
         next_aw_hold = 1'b1;
      end
      else if (wr_fire)
      begin
         next_aw_hold = 1'b0;
      end
      if (wvalid && wready)
      begin
         next_w_hold = 1'b1;
      end
      else if (wr_fire)
      begin
         next_w_hold = 1'b0;
      end
   end

   assign wr_fire = aw_hold && w_hold && !bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold   <= 1'b0;
         w_hold    <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end
      else
      begin
         aw_hold <= next_aw_hold;
         w_hold  <= next_w_hold;
         awready <= !next_aw_hold;
         wready  <= !next_w_hold;
         if (awvalid && awready)
         begin
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // writable offsets; the status and result words are read-only
   always_comb
   begin
      unique case (aw_addr_q)
         OFS_CTRL, OFS_FLAGS, OFS_SIMD_CSR, OFS_FEAT_LO, OFS_FEAT_HI,
         OFS_IMASK_LO, OFS_IMASK_HI, OFS_INUSE_LO, OFS_INUSE_HI,
         OFS_MOD_LO, OFS_MOD_HI, OFS_ADDR_LO, OFS_ADDR_HI,
         OFS_PRES_LO, OFS_PRES_HI, OFS_COMP_LO, OFS_COMP_HI: wr_hit = 1'b1;
         default:                                            wr_hit = 1'b0;
      endcase
   end

   assign ctrl_wr    = wr_fire && (aw_addr_q == OFS_CTRL) && w_strb_q[0];
   assign start_req  = ctrl_wr && w_data_q[CTRL_START_BIT] && (state == OSSU_IDLE);
   assign record_req = ctrl_wr && w_data_q[CTRL_RECORD_BIT];

   // context registers written by software only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_flags  <= '0;
         simd_csr   <= SIMD_CSR_INIT;
         feat_mask  <= MASK64_RESET;
         instr_mask <= MASK64_RESET;
         in_use     <= MASK64_RESET;
         modified   <= MASK64_RESET;
         save_addr  <= MASK64_RESET;
      end
      else if (wr_fire)
      begin
         unique case (aw_addr_q)
            OFS_FLAGS:    cpu_flags <= FLG_W'(merge_strb(32'(cpu_flags), w_data_q, w_strb_q));
            OFS_SIMD_CSR: simd_csr <= merge_strb(simd_csr, w_data_q, w_strb_q);
            OFS_FEAT_LO:  feat_mask[31:0] <= merge_strb(feat_mask[31:0], w_data_q, w_strb_q);
            OFS_FEAT_HI:  feat_mask[63:32] <= merge_strb(feat_mask[63:32], w_data_q, w_strb_q);
            OFS_IMASK_LO: instr_mask[31:0] <= merge_strb(instr_mask[31:0], w_data_q, w_strb_q);
            OFS_IMASK_HI: instr_mask[63:32] <= merge_strb(instr_mask[63:32], w_data_q, w_strb_q);
            OFS_INUSE_LO: in_use[31:0] <= merge_strb(in_use[31:0], w_data_q, w_strb_q);
            OFS_INUSE_HI: in_use[63:32] <= merge_strb(in_use[63:32], w_data_q, w_strb_q);
            OFS_MOD_LO:   modified[31:0] <= merge_strb(modified[31:0], w_data_q, w_strb_q);
            OFS_MOD_HI:   modified[63:32] <= merge_strb(modified[63:32], w_data_q, w_strb_q);
            OFS_ADDR_LO:  save_addr[31:0] <= merge_strb(save_addr[31:0], w_data_q, w_strb_q);
            OFS_ADDR_HI:  save_addr[63:32] <= merge_strb(save_addr[63:32], w_data_q, w_strb_q);
            default:      ;
         endcase
      end
   end

   // fault priority: invalid opcode, then device unavailable, then alignment
   always_comb
   begin
      next_fault = OSSU_FLT_NONE;
      if (!cpu_flags[FLG_OS_ENABLE])
      begin
         next_fault = OSSU_FLT_UD;
      end
      else if (cpu_flags[FLG_TASK_SW])
      begin
         next_fault = OSSU_FLT_NM;
      end
      else if (|save_addr[ALIGN_BITS-1:0])
      begin
         // alignment-check taken whenever permitted, so software sees one answer
         if (cpu_flags[FLG_ALIGN_MASK] && cpu_flags[FLG_ALIGN_CHECK] && (current_privilege_level == CPL_USER))
         begin
            next_fault = OSSU_FLT_AC;
         end
         else
         begin
            next_fault = OSSU_FLT_GP;
         end
      end
   end

   // a record that was never taken cannot enable the modified shortcut
   assign mod_eligible = lrr_valid && (lrr_cpl == current_privilege_level)
                         && (lrr_nonroot == cpu_flags[FLG_NONROOT])
                         && (lrr_addr == save_addr)
                         && (lrr_comp == MASK64_RESET);

   assign csr_not_init = (simd_csr != SIMD_CSR_INIT);

   // compacted form: old present field is never consulted
   always_comb
   begin
      c_present = requested_component_mask & in_use;
      c_store   = requested_component_mask & in_use;
      if (requested_component_mask[SSE_BIT] && csr_not_init)
      begin
         c_present[SSE_BIT] = 1'b1;
         c_store[SSE_BIT]   = 1'b1;
      end
   end

   // optimized form: init shortcut always, modified shortcut when eligible
   assign o_store = requested_component_mask & in_use & (mod_used ? modified : ~MASK64_RESET);

   // instruction sequencer; checks finish before the write state is entered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state      <= OSSU_IDLE;
         op_compact <= 1'b0;
         requested_component_mask       <= MASK64_RESET;
         fault      <= OSSU_FLT_NONE;
         mod_used   <= 1'b0;
      end
      else
      begin
         unique case (state)
            OSSU_IDLE:
            begin
               if (start_req)
               begin
                  op_compact <= w_data_q[CTRL_OP_BIT];
                  state      <= OSSU_CHECK;
               end
            end
            OSSU_CHECK:
            begin
               requested_component_mask     <= feat_mask & instr_mask;
               fault    <= next_fault;
               mod_used <= !op_compact && mod_eligible;
               state    <= (next_fault == OSSU_FLT_NONE) ? OSSU_WRITE : OSSU_DONE;
            end
            OSSU_WRITE:
            begin
               state <= OSSU_DONE;
            end
            OSSU_DONE:
            begin
               state <= OSSU_IDLE;
            end
         endcase
      end
   end

   // header image: software may preload it, the engine's write wins a collision
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hdr_present <= MASK64_RESET;
         hdr_compact <= MASK64_RESET;
      end
      else if (state == OSSU_WRITE)
      begin
         if (op_compact)
         begin
            hdr_present <= c_present;
            hdr_compact <= {1'b1, requested_component_mask[COMPACT_BIT-1:0]};
         end
         else
         begin
            // in-use bits only, so an off-init status register may still read as 0
            hdr_present <= (hdr_present & ~requested_component_mask) | (in_use & requested_component_mask);
         end
      end
      else if (wr_fire)
      begin
         unique case (aw_addr_q)
            OFS_PRES_LO: hdr_present[31:0] <= merge_strb(hdr_present[31:0], w_data_q, w_strb_q);
            OFS_PRES_HI: hdr_present[63:32] <= merge_strb(hdr_present[63:32], w_data_q, w_strb_q);
            OFS_COMP_LO: hdr_compact[31:0] <= merge_strb(hdr_compact[31:0], w_data_q, w_strb_q);
            OFS_COMP_HI: hdr_compact[63:32] <= merge_strb(hdr_compact[63:32], w_data_q, w_strb_q);
            default:     ;
         endcase
      end
   end

   // component stores; a faulted save leaves the previous result untouched
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         store_mask     <= MASK64_RESET;
         csr_stored     <= 1'b0;
         compact_layout <= 1'b0;
      end
      else if (state == OSSU_WRITE)
      begin
         compact_layout <= op_compact;
         if (op_compact)
         begin
            store_mask <= c_store;
            csr_stored <= c_store[SSE_BIT];
         end
         else
         begin
            store_mask <= o_store;
            csr_stored <= requested_component_mask[SSE_BIT] || requested_component_mask[AVX_BIT];
         end
      end
   end

   // last-restore record captured on a software restore notice
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lrr_valid   <= 1'b0;
         lrr_cpl     <= 2'h0;
         lrr_nonroot <= 1'b0;
         lrr_addr    <= MASK64_RESET;
         lrr_comp    <= MASK64_RESET;
      end
      else if (record_req)
      begin
         lrr_valid   <= 1'b1;
         lrr_cpl     <= current_privilege_level;
         lrr_nonroot <= cpu_flags[FLG_NONROOT];
         lrr_addr    <= save_addr;
         lrr_comp    <= hdr_compact;
      end
   end

   // completion flags and pins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         done_flag  <= 1'b0;
         save_done  <= 1'b0;
         save_fault <= 1'b0;
      end
      else
      begin
         save_done <= (state == OSSU_DONE);
         if (state == OSSU_DONE)
         begin
            done_flag  <= 1'b1;
            save_fault <= (fault != OSSU_FLT_NONE);
         end
         else if (start_req)
         begin
            done_flag <= 1'b0;
         end
      end
   end

   // read path
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (araddr)
         OFS_CTRL:       rd_word = {31'h0000_0000, op_compact} << CTRL_OP_BIT;
         OFS_STATUS:     rd_word = {24'h00_0000, compact_layout, csr_stored, mod_used,
                                    fault, done_flag, (state != OSSU_IDLE)};
         OFS_FLAGS:      rd_word = 32'(cpu_flags);
         OFS_SIMD_CSR:   rd_word = simd_csr;
         OFS_FEAT_LO:    rd_word = feat_mask[31:0];
         OFS_FEAT_HI:    rd_word = feat_mask[63:32];
         OFS_IMASK_LO:   rd_word = instr_mask[31:0];
         OFS_IMASK_HI:   rd_word = instr_mask[63:32];
         OFS_INUSE_LO:   rd_word = in_use[31:0];
         OFS_INUSE_HI:   rd_word = in_use[63:32];
         OFS_MOD_LO:     rd_word = modified[31:0];
         OFS_MOD_HI:     rd_word = modified[63:32];
         OFS_ADDR_LO:    rd_word = save_addr[31:0];
         OFS_ADDR_HI:    rd_word = save_addr[63:32];
         OFS_PRES_LO:    rd_word = hdr_present[31:0];
         OFS_PRES_HI:    rd_word = hdr_present[63:32];
         OFS_COMP_LO:    rd_word = hdr_compact[31:0];
         OFS_COMP_HI:    rd_word = hdr_compact[63:32];
         OFS_STORE_LO:   rd_word = store_mask[31:0];
         OFS_STORE_HI:   rd_word = store_mask[63:32];
         OFS_REQUESTED_COMPONENT_MASK_LO:    rd_word = requested_component_mask[31:0];
         OFS_REQUESTED_COMPONENT_MASK_HI:    rd_word = requested_component_mask[63:32];
         OFS_LRR_INFO:   rd_word = {28'h000_0000, lrr_valid, lrr_nonroot, lrr_cpl};
         OFS_LRR_ADR_LO: rd_word = lrr_addr[31:0];
         OFS_LRR_ADR_HI: rd_word = lrr_addr[63:32];
         OFS_LRR_CMP_LO: rd_word = lrr_comp[31:0];
         OFS_LRR_CMP_HI: rd_word = lrr_comp[63:32];
         default:        rd_hit  = 1'b0;
      endcase
   end

   assign ar_fire     = arvalid && arready;
   assign next_rvalid = ar_fire ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end
      else
      begin
         rvalid  <= next_rvalid;
         arready <= !next_rvalid;
         if (ar_fire)
         begin
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

endmodule

//--- ossu_pkg.sv
// constants, register map and types for the optimized state save unit
package ossu_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_STATUS     = 8'h04;
   localparam logic [7:0] OFS_FLAGS      = 8'h08;
   localparam logic [7:0] OFS_SIMD_CSR   = 8'h0C;
   localparam logic [7:0] OFS_FEAT_LO    = 8'h10;
   localparam logic [7:0] OFS_FEAT_HI    = 8'h14;
   localparam logic [7:0] OFS_IMASK_LO   = 8'h18;
   localparam logic [7:0] OFS_IMASK_HI   = 8'h1C;
   localparam logic [7:0] OFS_INUSE_LO   = 8'h20;
   localparam logic [7:0] OFS_INUSE_HI   = 8'h24;
   localparam logic [7:0] OFS_MOD_LO     = 8'h28;
   localparam logic [7:0] OFS_MOD_HI     = 8'h2C;
   localparam logic [7:0] OFS_ADDR_LO    = 8'h30;
   localparam logic [7:0] OFS_ADDR_HI    = 8'h34;
   localparam logic [7:0] OFS_PRES_LO    = 8'h38;
   localparam logic [7:0] OFS_PRES_HI    = 8'h3C;
   localparam logic [7:0] OFS_COMP_LO    = 8'h40;
   localparam logic [7:0] OFS_COMP_HI    = 8'h44;
   localparam logic [7:0] OFS_STORE_LO   = 8'h48;
   localparam logic [7:0] OFS_STORE_HI   = 8'h4C;
   localparam logic [7:0] OFS_REQUESTED_COMPONENT_MASK_LO    = 8'h50;
   localparam logic [7:0] OFS_REQUESTED_COMPONENT_MASK_HI    = 8'h54;
   localparam logic [7:0] OFS_LRR_INFO   = 8'h58;
   localparam logic [7:0] OFS_LRR_ADR_LO = 8'h5C;
   localparam logic [7:0] OFS_LRR_ADR_HI = 8'h60;
   localparam logic [7:0] OFS_LRR_CMP_LO = 8'h64;
   localparam logic [7:0] OFS_LRR_CMP_HI = 8'h68;

   // control register fields
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_OP_BIT     = 1;
   localparam int CTRL_RECORD_BIT = 2;

   // processor flag register fields
   localparam int FLG_OS_ENABLE   = 0;
   localparam int FLG_TASK_SW     = 1;
   localparam int FLG_ALIGN_MASK  = 2;
   localparam int FLG_ALIGN_CHECK = 3;
   localparam int FLG_CPL_LSB     = 4;
   localparam int FLG_NONROOT     = 6;
   localparam int FLG_W           = 7;

   // component and header positions
   localparam int SSE_BIT     = 1;
   localparam int AVX_BIT     = 2;
   localparam int COMPACT_BIT = 63;
   localparam int ALIGN_BITS  = 6;

   localparam logic [1:0]  CPL_USER       = 2'h3;
   localparam logic [31:0] SIMD_CSR_INIT  = 32'h0000_1F80;
   localparam logic [63:0] MASK64_RESET   = 64'h0000_0000_0000_0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [2:0] {
      OSSU_FLT_NONE = 3'h0,
      OSSU_FLT_UD   = 3'h1,
      OSSU_FLT_NM   = 3'h2,
      OSSU_FLT_GP   = 3'h3,
      OSSU_FLT_AC   = 3'h4
   } ossu_fault_e;

   // gray path idle -> check -> write -> done -> idle
   typedef enum logic [1:0] {
      OSSU_IDLE  = 2'b00,
      OSSU_CHECK = 2'b01,
      OSSU_WRITE = 2'b11,
      OSSU_DONE  = 2'b10
   } ossu_state_e;

endpackage

//--- ossu_props.sv
// bus handshake and save completion checker for the state save unit
`timescale 1ns/10ps
module ossu_props
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // watched handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic save_done,
   input wire logic save_fault
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   b_stands_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
   r_stands_a: assert property (rvalid && !rready |=> rvalid) else $error("rvalid dropped");
   ar_block_a: assert property (rvalid |-> !arready) else $error("arready while rvalid");
   aw_taken_a: assert property (awvalid && awready |=> !awready) else $error("awready stuck");
   w_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid
      |-> ##[1:2] bvalid) else $error("write not answered");
   r_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid) else $error("no rvalid");
   done_pulse_a: assert property (save_done |=> !save_done) else $error("done not a pulse");
   fault_sync_a: assert property ($changed(save_fault) |-> save_done)
      else $error("fault flag moved alone");
   reset_quiet_a: assert property ($rose(aresetn) |-> (!awready && !save_done)
      ##1 (awready && arready)) else $error("bad reset release");
   cover property (save_done && save_fault);
   cover property (save_done && !save_fault);
   cover property (rvalid && rready);
endmodule
bind ossu_state_save_unit ossu_props u_ossu_props (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .save_done,
   .save_fault);

//--- ossu_axi_master.sv
// axi4-lite master model that software uses to reach the save unit
`timescale 1ns/10ps
module ossu_axi_master
(
   input  wire logic        aclk,
   // write side
   output logic [7:0]       awaddr,
   output logic [2:0]       awprot,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic        bvalid,
   input  wire logic [1:0]  bresp,
   output logic             bready,
   // read side
   output logic [7:0]       araddr,
   output logic [2:0]       arprot,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial
   begin
      {awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arprot, arvalid, rready} = '0;
      wstrb = 4'hF;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ap;
      logic wp;
      ap = 1'b1;
      wp = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap || wp)
      begin
         @(posedge aclk);
         if (ap && awready)
         begin
            awvalid <= 1'b0;
            ap = 1'b0;
         end
         if (wp && wready)
         begin
            wvalid <= 1'b0;
            wp = 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

//--- optimized_state_save_unit_test.sv
// register-level tests of both save forms, faults and the bus
`timescale 1ns/10ps
module optimized_state_save_unit_test;
   import ossu_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, save_done, save_fault;
   int fail_count = 0;
   int n_checks = 0;
   logic [31:0] fl [4] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0001, 32'h0000_003D};
   logic [31:0] fs [4] = '{32'h0000_0006, 32'h0000_000A, 32'h0000_000E, 32'h0000_0012};
   always #12.5 aclk = ~aclk;
   ossu_state_save_unit u_ossu_state_save_unit (.*);
   ossu_axi_master u_ossu_axi_master (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] s;
      u_ossu_axi_master.wr(a, d, s);
      chk({30'h0, s}, {30'h0, RESP_OKAY});
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] s;
      u_ossu_axi_master.rd(a, d, s);
      chk(d, e);
   endtask
   // waits for the completion pulse, then checks the fault flag beside it
   task automatic save(input logic [31:0] op, input logic f);
      w(OFS_CTRL, op);
      do @(posedge aclk); while (save_done !== 1'b1);
      chk({31'h0, save_fault}, {31'h0, f});
   endtask
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #400000;
      fail_count++;
      wrap_up();
   end
   initial
   begin
      logic [31:0] d;
      logic [1:0] s;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      w(OFS_FEAT_LO, 32'h0000_000F);
      w(OFS_IMASK_LO, 32'h0000_0006);
      w(OFS_INUSE_LO, 32'h0000_0004);
      w(OFS_PRES_LO, 32'h0000_0011);
      w(OFS_COMP_LO, 32'h0000_0055);
      for (int i = 0; i < 4; i++)
      begin
         w(OFS_FLAGS, fl[i]);
         w(OFS_ADDR_LO, (i > 1) ? 32'h0000_0020 : 32'h0000_0000);
         save(32'h0000_0001, 1'b1);
         r(OFS_STATUS, fs[i]);
         r(OFS_PRES_LO, 32'h0000_0011);
      end
      w(OFS_FLAGS, 32'h0000_0001);
      w(OFS_ADDR_LO, 32'h0000_0000);
      w(OFS_IMASK_LO, 32'h0000_0004);
      save(32'h0000_0001, 1'b0);
      r(OFS_REQUESTED_COMPONENT_MASK_LO, 32'h0000_0004);
      r(OFS_PRES_LO, 32'h0000_0015);
      r(OFS_COMP_LO, 32'h0000_0055);
      r(OFS_STATUS, 32'h0000_0042);
      w(OFS_IMASK_LO, 32'h0000_0006);
      save(32'h0000_0003, 1'b0);
      r(OFS_PRES_LO, 32'h0000_0004);
      r(OFS_COMP_LO, 32'h0000_0006);
      r(OFS_COMP_HI, 32'h8000_0000);
      w(OFS_SIMD_CSR, 32'h0000_0000);
      save(32'h0000_0003, 1'b0);
      r(OFS_PRES_LO, 32'h0000_0006);
      r(OFS_STORE_LO, 32'h0000_0006);
      r(OFS_STATUS, 32'h0000_00C2);
      w(OFS_IMASK_LO, 32'h0000_0004);
      save(32'h0000_0003, 1'b0);
      r(OFS_STATUS, 32'h0000_0082);
      // restore notice while the header still holds a compacted form
      w(OFS_CTRL, 32'h0000_0004);
      r(OFS_LRR_CMP_HI, 32'h8000_0000);
      w(OFS_IMASK_LO, 32'h0000_0006);
      save(32'h0000_0001, 1'b0);
      r(OFS_STORE_LO, 32'h0000_0004);
      r(OFS_PRES_LO, 32'h0000_0004);
      w(OFS_COMP_LO, 32'h0000_0000);
      w(OFS_COMP_HI, 32'h0000_0000);
      w(OFS_CTRL, 32'h0000_0004);
      save(32'h0000_0001, 1'b0);
      r(OFS_STATUS, 32'h0000_0062);
      r(OFS_STORE_LO, 32'h0000_0000);
      save(32'h0000_0003, 1'b0);
      r(OFS_STATUS, 32'h0000_00C2);
      w(OFS_MOD_LO, 32'h0000_0004);
      save(32'h0000_0001, 1'b0);
      r(OFS_STORE_LO, 32'h0000_0004);
      u_ossu_axi_master.wr(OFS_STATUS, 32'h0000_0001, s);
      chk({30'h0, s}, {30'h0, RESP_SLVERR});
      // a mid-run reset must bring the context back to its idle values
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      r(OFS_SIMD_CSR, SIMD_CSR_INIT);
      r(OFS_PRES_LO, 32'h0000_0000);
      u_ossu_axi_master.rd(8'hFC, d, s);
      chk({30'h0, s}, {30'h0, RESP_SLVERR});
      wrap_up();
   end
endmodule
